/* File: logic/adc_format_pkg.sv */
package adc_format_pkg;
  // ----------------------------------------------------------------
  // Register map (word offsets on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [2:0] OFF_CTRL_A   = 3'h0;
  localparam logic [2:0] OFF_CTRL_B   = 3'h1;
  localparam logic [2:0] OFF_RES_HIGH = 3'h2;
  localparam logic [2:0] OFF_RES_LOW  = 3'h3;
  localparam logic [2:0] OFF_IRQ_STAT = 3'h4;
  localparam logic [2:0] OFF_IRQ_MASK = 3'h5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CLK_SEL_HI  = 7;
  localparam int CLK_SEL_LO  = 6;
  localparam int CHAN_HI     = 5;
  localparam int CHAN_LO     = 2;
  localparam int GO_BIT      = 1;
  localparam int ENABLE_BIT  = 0;
  localparam int JUSTIFY_BIT = 7;
  localparam int VREF_NEG_BIT = 5;
  localparam int VREF_POS_BIT = 4;
  localparam int DONE_IRQ_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_MASK  = 8'hB0;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
  localparam logic [3:0] CHAN_FIXED_REF = 4'hF;
  localparam logic [3:0] CONV_BITS      = 4'hB;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_REQUEST = 2'b01,
    ST_WAIT    = 2'b10
  } conv_state_t;
endpackage : adc_format_pkg

/* File: logic/adc_result_format_control.sv */
// Behaviour
// R1 - Left justified, result bits 9..2 go to high byte bits 7..0.
// R2 - Left justified, result bits 1..0 go to low byte bits 7..6, bits 5..0 are reserved.
// R3 - Right justified, result bits 9..8 go to high byte bits 1..0, bits 7..2 are reserved.
// R4 - Right justified, result bits 7..0 go to low byte bits 7..0.
// R5 - Software waits an acquisition interval after a channel change before setting go.
// R6 - Control A holds clock select 7..6, channel 5..2, go 1 and enable 0.
// R7 - Both result bytes power up unknown and are software readable and writable at any time; a write in a completion cycle is overridden by the result.
// R8 - Justify select one means right justified, zero means left justified.
// R9 - Go set while enabled starts a conversion; hardware clears go at completion.
// R10 - Channel code all ones routes the fixed internal reference to the converter.
// R11 - Both result bytes are loaded together before go is cleared.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module adc_result_format_control
  import adc_format_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdata,
  output logic            convStart,
  input  wire logic       convDone,
  input  wire logic [9:0] conversionResult,
  output logic      [3:0] inputChannelSelect,
  output logic            fixedRefSelect,
  output logic      [1:0] conversionClockSelect,
  output logic            converterEnable,
  output logic            vrefNegSelect,
  output logic            vrefPosSelect,
  output logic            irq
);
  import adc_format_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  ctrlA_q, ctrlA_d;
  logic [7:0]  ctrlB_q, ctrlB_d;
  logic [7:0]  resHigh_q, resHigh_d;
  logic [7:0]  resLow_q, resLow_d;
  logic [7:0]  irqStat_q, irqStat_d;
  logic [7:0]  irqMask_q, irqMask_d;
  logic [7:0]  rdata_q, rdata_d;
  conv_state_t state_q, state_d;
  logic        doneEvent;
  logic [7:0]  fmtHigh;
  logic [7:0]  fmtLow;
  logic        abortEvent;
  logic        wrCtrlA;
  logic        wrCtrlB;
  logic        wrResHigh;
  logic        wrResLow;
  logic        wrIrqStat;
  logic        wrIrqMask;
  logic        fixedRef_q, fixedRef_d;
  logic        irq_q, irq_d;

  // ----------------------------------------------------------------
  // Result formatting
  // ----------------------------------------------------------------
  // Reserved bits are driven zero rather than left floating
  always_comb
  begin
    if (ctrlB_q[JUSTIFY_BIT]) // [R8]
    begin
      fmtHigh = {6'h00, conversionResult[9:8]}; // [R3]
      fmtLow  = conversionResult[7:0]; // [R4]
    end
    else
    begin
      fmtHigh = conversionResult[9:2]; // [R1]
      fmtLow  = {conversionResult[1:0], 6'h00}; // [R2]
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------
  // The acquisition wait is software's duty; go is honoured as soon as it is set [R5]
  always_comb
  begin
    state_d    = state_q;
    doneEvent  = 1'b0;
    abortEvent = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (ctrlA_q[GO_BIT] && ctrlA_q[ENABLE_BIT]) // [R9]
          state_d = ST_REQUEST;
      end
      ST_REQUEST:
      begin
        state_d = ST_WAIT;
      end
      ST_WAIT:
      begin
        // Dropping the enable mid-conversion abandons it; no result is kept
        if (!ctrlA_q[ENABLE_BIT])
        begin
          abortEvent = 1'b1;
          state_d    = ST_IDLE;
        end
        else if (convDone)
        begin
          doneEvent = 1'b1;
          state_d   = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  assign convStart = (state_q == ST_REQUEST);

  // The request state lasts exactly one cycle, which is what keeps convStart a single pulse
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // One strobe per register keeps the address map out of the groups below
  assign wrCtrlA   = regWrite && (regAddr == OFF_CTRL_A);
  assign wrCtrlB   = regWrite && (regAddr == OFF_CTRL_B);
  assign wrResHigh = regWrite && (regAddr == OFF_RES_HIGH);
  assign wrResLow  = regWrite && (regAddr == OFF_RES_LOW);
  assign wrIrqStat = regWrite && (regAddr == OFF_IRQ_STAT);
  assign wrIrqMask = regWrite && (regAddr == OFF_IRQ_MASK);

  // ----------------------------------------------------------------
  // Control A
  // ----------------------------------------------------------------
  always_comb
  begin
    ctrlA_d = ctrlA_q;
    if (wrCtrlA)
      ctrlA_d = regWdata; // [R6]
    // Completion and abort come after the software write, so hardware has the last word on go
    if (doneEvent || abortEvent)
      ctrlA_d[GO_BIT] = 1'b0; // [R9]
    // Decoded ahead of the register so the select leaves a flip-flop like the other fields
    fixedRef_d = (ctrlA_d[CHAN_HI:CHAN_LO] == CHAN_FIXED_REF); // [R10]
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrlA_q    <= CTRL_A_RESET;
      fixedRef_q <= (CTRL_A_RESET[CHAN_HI:CHAN_LO] == CHAN_FIXED_REF);
    end
    else
    begin
      ctrlA_q    <= ctrlA_d;
      fixedRef_q <= fixedRef_d;
    end
  end

  // ----------------------------------------------------------------
  // Control B
  // ----------------------------------------------------------------
  // Only the justify and reference bits exist; the rest read back as zero
  always_comb
  begin
    ctrlB_d = ctrlB_q;
    if (wrCtrlB)
      ctrlB_d = regWdata & CTRL_B_MASK; // [R8]
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      ctrlB_q <= CTRL_B_RESET;
    else
      ctrlB_q <= ctrlB_d;
  end

  // ----------------------------------------------------------------
  // Result bytes
  // ----------------------------------------------------------------
  always_comb
  begin
    resHigh_d = resHigh_q;
    resLow_d  = resLow_q;
    if (wrResHigh)
      resHigh_d = regWdata; // [R7]
    if (wrResLow)
      resLow_d = regWdata; // [R7]
    // A completion beats a software write in the same cycle, so a completion always leaves both bytes holding one sample
    if (doneEvent)
    begin
      resHigh_d = fmtHigh; // [R11]
      resLow_d  = fmtLow; // [R11]
    end
  end

  // Result bytes have no reset: their power-up value is undefined by design
  always_ff @(posedge mclk)
  begin
    resHigh_q <= resHigh_d;
    resLow_q  <= resLow_d;
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  always_comb
  begin
    irqStat_d = irqStat_q;
    if (wrIrqStat)
      irqStat_d = irqStat_q & ~regWdata;
    // Set is applied after the clear so a completion is never lost to a same-cycle write
    if (doneEvent)
      irqStat_d[DONE_IRQ_BIT] = 1'b1;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      irqStat_q <= 8'h00;
    else
      irqStat_q <= irqStat_d;
  end

  // ----------------------------------------------------------------
  // Interrupt mask and line
  // ----------------------------------------------------------------
  // Only the completion event exists, so only mask bit 0 is kept
  always_comb
  begin
    irqMask_d = irqMask_q;
    if (wrIrqMask)
      irqMask_d = regWdata & 8'h01;
    // Built from next values so the registered line moves in step with the status bit
    irq_d = |(irqStat_d & irqMask_d);
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irqMask_q <= IRQ_MASK_RESET;
      irq_q     <= 1'b0;
    end
    else
    begin
      irqMask_q <= irqMask_d;
      irq_q     <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped offsets read as zero rather than aliasing a register
  always_comb
  begin
    rdata_d = 8'h00;
    if (regRead)
    begin
      case (regAddr)
        OFF_CTRL_A:   rdata_d = ctrlA_q;
        OFF_CTRL_B:   rdata_d = ctrlB_q;
        OFF_RES_HIGH: rdata_d = resHigh_q;
        OFF_RES_LOW:  rdata_d = resLow_q;
        OFF_IRQ_STAT: rdata_d = irqStat_q;
        OFF_IRQ_MASK: rdata_d = irqMask_q;
        default:      rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regRdata              = rdata_q;
  assign inputChannelSelect    = ctrlA_q[CHAN_HI:CHAN_LO];
  assign fixedRefSelect        = fixedRef_q; // [R10]
  assign conversionClockSelect = ctrlA_q[CLK_SEL_HI:CLK_SEL_LO];
  assign converterEnable       = ctrlA_q[ENABLE_BIT];
  assign vrefNegSelect         = ctrlB_q[VREF_NEG_BIT];
  assign vrefPosSelect         = ctrlB_q[VREF_POS_BIT];
  assign irq                   = irq_q;
endmodule : adc_result_format_control

/* File: bench/adc_result_format_control_checker.sv */
`timescale 1ns/1ps
module adc_result_format_control_checker
  import adc_format_pkg::*;
(
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  input wire logic       convStart,
  input wire logic [3:0] inputChannelSelect,
  input wire logic       fixedRefSelect,
  input wire logic       converterEnable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence goWrite(logic [1:0] low);
    regWrite && regAddr == OFF_CTRL_A && regWdata[1:0] == low && !converterEnable;
  endsequence
  sequence readOf(logic [2:0] a);
    regRead && regAddr == a;
  endsequence
  a_go_starts: assert property (goWrite(2'h3) |=> ##1 convStart)
    else $error("go did not start");
  a_start_single: assert property (convStart |=> !convStart)
    else $error("start pulse too long");
  a_go_refused: assert property (goWrite(2'h2) |=> (!convStart)[*2])
    else $error("start while disabled");
  a_fixed_ref: assert property (fixedRefSelect == (inputChannelSelect == CHAN_FIXED_REF))
    else $error("fixed reference decode");
  a_field_map: assert property (regWrite && regAddr == OFF_CTRL_A
    |=> inputChannelSelect == $past(regWdata[5:2]) && converterEnable == $past(regWdata[0]))
    else $error("control A fields");
  a_readback_a: assert property (readOf(OFF_CTRL_A)
    |=> {regRdata[5:2], regRdata[0]} == {$past(inputChannelSelect), $past(converterEnable)})
    else $error("control A readback");
  a_ctrl_b_gaps: assert property (readOf(OFF_CTRL_B) |=> regRdata[6] == 1'h0 && regRdata[3:0] == 4'h0)
    else $error("control B unused bits");
  a_rdata_idle: assert property (!$past(regRead) |-> regRdata == 8'h00)
    else $error("read data outside its cycle");
endmodule : adc_result_format_control_checker

bind adc_result_format_control adc_result_format_control_checker chk (.mclk(mclk), .arst_n(arst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .convStart(convStart), .inputChannelSelect(inputChannelSelect), .fixedRefSelect(fixedRefSelect),
  .converterEnable(converterEnable));

/* File: bench/analog_side_model.sv */
`timescale 1ns/1ps
module analog_side_model #(
  parameter logic [9:0] FIXED_CODE = 10'h0C5
)
(
  input  wire logic       mclk,
  input  wire logic       convStart,
  input  wire logic       fixedRefSelect,
  input  wire logic [9:0] sampleValue,
  input  wire logic [3:0] latency,
  output logic            convDone = 1'h0,
  output logic      [9:0] conversionResult = 10'h3FF
);
  int         cnt = -1;
  logic [9:0] held = 10'h000;
  // Result lines only carry data with the done pulse; otherwise they show the inverse
  always @(posedge mclk)
  begin
    convDone <= 1'h0;
    conversionResult <= ~held;
    if (convStart)
    begin
      cnt <= latency;
      held <= fixedRefSelect ? FIXED_CODE : sampleValue;
    end
    else if (cnt == 0)
    begin
      convDone <= 1'h1;
      conversionResult <= held;
      cnt <= -1;
    end
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule : analog_side_model

/* File: bench/adc_result_format_control_tb.sv */
`timescale 1ns/1ps
module adc_result_format_control_tb;
  import adc_format_pkg::*;
  localparam logic [9:0] FIXED_CODE = 10'h0C5;
  logic       mclk = 1'h0, arst_n = 1'h0, regWrite = 1'h0, regRead = 1'h0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00, regRdata;
  logic [9:0] sampleValue = 10'h000, conversionResult;
  logic [3:0] latency = 4'h2, inputChannelSelect;
  logic [1:0] clkSel;
  logic       convStart, convDone, fixedRefSelect, converterEnable, vNeg, vPos, irq;
  int         fail_count = 0, checked = 0;
  always #2.5 mclk = ~mclk;
  adc_result_format_control DUT (.mclk(mclk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .convStart(convStart), .convDone(convDone),
    .conversionResult(conversionResult), .inputChannelSelect(inputChannelSelect), .irq(irq),
    .fixedRefSelect(fixedRefSelect), .conversionClockSelect(clkSel), .converterEnable(converterEnable),
    .vrefNegSelect(vNeg), .vrefPosSelect(vPos));
  analog_side_model #(.FIXED_CODE(FIXED_CODE)) farSide (.mclk(mclk), .convStart(convStart),
    .fixedRefSelect(fixedRefSelect), .sampleValue(sampleValue), .latency(latency), .convDone(convDone),
    .conversionResult(conversionResult));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWrite <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWrite <= 1'h0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk);
    regRead <= 1'h1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'h0;
    #1 check(regRdata, exp);
  endtask : rd
  // ------------------------------------------
  // One conversion, judged through the registers and the output ports
  // ------------------------------------------
  task automatic convert(input logic [3:0] ch, input logic right, input logic m, input logic [9:0] v);
    int i;
    sampleValue <= (ch == CHAN_FIXED_REF) ? ~v : v;
    latency <= latency + 4'h5;
    wr(OFF_IRQ_MASK, {7'h00, m});
    wr(OFF_CTRL_B, {right, 7'h00});
    wr(OFF_CTRL_A, {2'h2, ch, 2'h0});
    repeat (6) @(posedge mclk);
    wr(OFF_CTRL_A, {2'h2, ch, 2'h3});
    for (i = 0; i < 40 && convDone !== 1'h1; i++) @(posedge mclk);
    if (i == 40) fail_count++;
    if (i == 40) tally_and_finish();
    #1 check({7'h00, irq}, {7'h00, m});
    check({6'h00, clkSel}, 8'h02);
    check({4'h0, inputChannelSelect}, {4'h0, ch});
    check({7'h00, fixedRefSelect}, {7'h00, (ch == CHAN_FIXED_REF)});
    rd(OFF_CTRL_A, {2'h2, ch, 2'h1});
    rd(OFF_RES_HIGH, right ? {6'h00, v[9:8]} : v[9:2]);
    rd(OFF_RES_LOW, right ? v[7:0] : {v[1:0], 6'h00});
    rd(OFF_IRQ_STAT, 8'h01);
    wr(OFF_IRQ_STAT, 8'h01);
    #1 check({7'h00, irq}, 8'h00);
  endtask : convert
  // ------------------------------------------
  // Enable dropped while a conversion is pending
  // ------------------------------------------
  task automatic abort_conversion();
    int i;
    latency <= 4'hF;
    wr(OFF_CTRL_A, 8'h80);
    repeat (6) @(posedge mclk);
    wr(OFF_CTRL_A, 8'h83);
    repeat (4) @(posedge mclk);
    wr(OFF_CTRL_A, 8'h82);
    rd(OFF_CTRL_A, 8'h80);
    for (i = 0; i < 24; i++) @(posedge mclk);
    rd(OFF_IRQ_STAT, 8'h00);
    rd(OFF_RES_HIGH, FIXED_CODE[9:2]);
  endtask : abort_conversion
  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'h1;
    rd(OFF_CTRL_A, 8'h00);
    rd(OFF_CTRL_B, 8'h00);
    wr(OFF_CTRL_A, 8'h02);
    rd(OFF_CTRL_A, 8'h02);
    convert(4'h3, 1'h0, 1'h1, 10'h2A5);
    convert(4'h9, 1'h1, 1'h0, 10'h35A);
    convert(CHAN_FIXED_REF, 1'h0, 1'h1, FIXED_CODE);
    abort_conversion();
    wr(OFF_CTRL_B, 8'hFF);
    rd(OFF_CTRL_B, 8'hB0);
    check({6'h00, vNeg, vPos}, 8'h03);
    wr(OFF_RES_HIGH, 8'h5A);
    wr(OFF_RES_LOW, 8'hC3);
    rd(OFF_RES_HIGH, 8'h5A);
    rd(OFF_RES_LOW, 8'hC3);
    rd(3'h7, 8'h00);
    tally_and_finish();
  end
endmodule : adc_result_format_control_tb
